// ---- dv/sfd_link_props.sv ----
// Concurrent checks on the serial link joining the host end and the device end.
module sfd_link_props (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic miso_out,
	input wire logic miso_oe,
	input wire logic miso
);
	// ----------------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------------
	// Serial clock edges since select fell; it saturates so a long read never wraps into the first byte.
	logic [4:0] edges;
	logic [5:0] sh;

	always_ff @(posedge ref_clk) begin
		sh <= {sh[4:0], sclk};
		if (rst || ss_n)
			edges <= 5'h00;
		else if ($changed(sclk) && edges != 5'h1F)
			edges <= edges + 5'h01;
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// ----------------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------------
	property p_released_idle;
		ss_n && $past(ss_n) && $past(ss_n, 2) && $past(ss_n, 3) && $past(ss_n, 4) |-> !miso_oe;
	endproperty
	a_released_idle: assert property (p_released_idle) else $error("miso driven while select is high");

	property p_no_status_early;
		!ss_n && edges < 5'h09 |-> !miso_oe;
	endproperty
	a_no_status_early: assert property (p_no_status_early) else $error("miso driven in status bit times 1-4");

	property p_last_status_released;
		$rose(edges == 5'h0F) |-> ##5 !miso_oe;
	endproperty
	a_last_status_released: assert property (p_last_status_released) else $error("last status bit driven");

	property p_ack_high;
		$rose(edges == 5'h0D) |-> ##5 (!miso_oe || miso_out);
	endproperty
	a_ack_high: assert property (p_ack_high) else $error("address-match bit driven low");

	property p_half_period;
		!ss_n && $changed(sclk) |=> $stable(sclk) [*7];
	endproperty
	a_half_period: assert property (p_half_period) else $error("serial clock half period too short");

	property p_mosi_on_edges;
		!ss_n && $changed(mosi) |-> $changed(sclk);
	endproperty
	a_mosi_on_edges: assert property (p_mosi_on_edges) else $error("mosi moved away from a clock edge");

	property p_oe_after_edge;
		$rose(miso_oe) |-> (sh[1] ^ sh[2]) || (sh[2] ^ sh[3]) || (sh[3] ^ sh[4]) || (sh[4] ^ sh[5]);
	endproperty
	a_oe_after_edge: assert property (p_oe_after_edge) else $error("miso drive started off a clock edge");

	// Every driven stretch spans at least one serial clock half period of eight cycles.
	property p_oe_holds;
		$rose(miso_oe) |-> miso_oe [*8];
	endproperty
	a_oe_holds: assert property (p_oe_holds) else $error("miso drive dropped inside a bit time");

	c_drive: cover property ($rose(miso_oe));
	c_data_byte: cover property (!ss_n && $rose(edges == 5'h11));
	c_frame_end: cover property ($rose(ss_n));
endmodule : sfd_link_props

// ---- dv/tb.sv ----
// Self-checking bench driving both ends over APB and comparing the bytes they exchange.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sfd_pkg::*;

	logic                ref_clk = 1'b0;
	logic                rst     = 1'b1;
	logic [1:0]          psel;
	logic [1:0]          penable;
	logic [1:0]          pwrite;
	logic [ADDR_W-1:0]   paddr [2];
	logic [DATA_W-1:0]   pwdata [2];
	wire  [DATA_W-1:0]   prdata [2];
	wire                 pready [2];
	wire                 pslverr [2];
	int                  fails = 0;
	int                  samples_checked = 0;
	int                  cycles = 0;
	logic [31:0]         seed = 32'h0000_001C;

	sfd_link_if link ();
	sfd_master_end i_sfd_master_end (.ref_clk(ref_clk), .rst(rst), .link(link), .psel(psel[0]),
		.penable(penable[0]), .pwrite(pwrite[0]), .paddr(paddr[0]), .pwdata(pwdata[0]),
		.prdata(prdata[0]), .pready(pready[0]), .pslverr(pslverr[0]));
	sfd_slave_end i_sfd_slave_end (.ref_clk(ref_clk), .rst(rst), .link(link), .psel(psel[1]),
		.penable(penable[1]), .pwrite(pwrite[1]), .paddr(paddr[1]), .pwdata(pwdata[1]),
		.prdata(prdata[1]), .pready(pready[1]), .pslverr(pslverr[1]));
	sfd_link_props i_sfd_link_props (.ref_clk(ref_clk), .rst(rst), .sclk(link.sclk), .ss_n(link.ss_n),
		.mosi(link.mosi), .miso_out(link.miso_out), .miso_oe(link.miso_oe), .miso(link.miso));

	always #20 ref_clk = ~ref_clk;

	// ----------------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// Released bit times read as the pull-up level.
	function automatic logic [7:0] stat(input logic transmit_empty_flag, input logic receive_full_flag);
		return {4'hF, transmit_empty_flag, receive_full_flag, 2'h3};
	endfunction : stat

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic apb(input int s, input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		@(posedge ref_clk);
		psel[s] <= 1'b1;
		pwrite[s] <= w;
		paddr[s] <= a;
		pwdata[s] <= wd;
		@(posedge ref_clk);
		penable[s] <= 1'b1;
		do @(posedge ref_clk); while (pready[s] !== 1'b1);
		rd = prdata[s];
		er = pslverr[s];
		psel[s] <= 1'b0;
		penable[s] <= 1'b0;
	endtask : apb

	task automatic wr(input int s, input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(s, 1'b1, a, d, r, e);
	endtask : wr

	task automatic rd_chk(input int s, input logic [7:0] a, input logic [31:0] exp, input string name);
		logic [31:0] r;
		logic        e;
		apb(s, 1'b0, a, 32'h0000_0000, r, e);
		check(name, r, exp);
	endtask : rd_chk

	// One byte through the host: start it, poll busy, then take what came back on miso.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		logic [31:0] r;
		logic        e;
		wr(0, 8'h08, {24'h00_0000, tx});
		do apb(0, 1'b0, 8'h04, 32'h0000_0000, r, e); while (r[0] !== 1'b0);
		apb(0, 1'b0, 8'h0C, 32'h0000_0000, r, e);
		rx = r[7:0];
	endtask : xfer

	task automatic sel(input logic cpol, input logic on);
		wr(0, 8'h00, {29'h0000_0000, 1'b1, cpol, on});
		// Select moves up to two cycles later and the device syncs it in two more.
		repeat (4) @(posedge ref_clk);
	endtask : sel

	task automatic dcfg(input logic cpol, input logic cpha, input logic [2:0] a);
		wr(1, 8'h00, {26'h000_0000, 1'b1, cpha, cpol, a});
	endtask : dcfg

	// ----------------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------------
	// Eighteen bytes of some hundred and fifty cycles each fit well inside this ceiling.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fails++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------
	initial begin
		logic [31:0] r;
		logic [31:0] d;
		logic        e;
		logic [7:0]  rx;
		logic [2:0]  a;
		psel = 2'h0;
		penable = 2'h0;
		pwrite = 2'h0;
		paddr = '{default: '0};
		pwdata = '{default: '0};
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		rd_chk(1, 8'h00, 32'h0000_0010, "dev_ctrl_reset");
		rd_chk(1, 8'h04, 32'h0000_0001, "dev_status_reset");
		rd_chk(0, 8'h00, 32'h0000_0004, "host_ctrl_reset");
		for (int s = 0; s < 2; s++) begin
			apb(s, 1'b0, 8'h22, 32'h0000_0000, r, e);
			check("unmapped_err", e, 32'h0000_0001);
			check("unmapped_data", r, 32'h0000_0000);
		end
		check("miso_idle", link.miso, 32'h0000_0001);
		// Modes 1 and 3: a write frame that overruns, then a read frame that repeats old data.
		for (int m = 0; m < 2; m++) begin
			r = xs();
			a = r[2:0];
			d = xs();
			dcfg(m[0], 1'b1, a);
			sel(m[0], 1'b1);
			xfer({a, 1'b0, d[3:0]}, rx);
			check("wr_cmd_status", rx, stat(1'b1, 1'b0));
			xfer(d[11:4], rx);
			check("wr_d1_status", rx, stat(1'b1, 1'b0));
			xfer(d[19:12], rx);
			check("wr_d2_status", rx, stat(1'b1, 1'b1));
			sel(m[0], 1'b0);
			rd_chk(1, 8'h04, 32'h0000_0007, "dev_status_ovr");
			rd_chk(1, 8'h0C, {24'h00_0000, d[11:4]}, "dev_rx");
			rd_chk(1, 8'h04, 32'h0000_0005, "dev_status_taken");
			wr(1, 8'h04, 32'h0000_0004);
			rd_chk(1, 8'h04, 32'h0000_0001, "dev_status_clr");
			wr(1, 8'h08, {24'h00_0000, d[27:20]});
			rd_chk(1, 8'h04, 32'h0000_0000, "dev_txe_low");
			sel(m[0], 1'b1);
			xfer({a, 1'b1, d[7:4]}, rx);
			check("rd_cmd_status", rx, stat(1'b0, 1'b0));
			xfer(d[31:24], rx);
			check("rd_data1", rx, {24'h00_0000, d[27:20]});
			xfer(d[15:8], rx);
			check("rd_status2", rx, stat(1'b1, 1'b0));
			xfer(d[23:16], rx);
			check("rd_data2", rx, {24'h00_0000, d[27:20]});
			sel(m[0], 1'b0);
		end
		// Refused frames: a foreign address, then a phase 0 device setting.
		for (int k = 0; k < 2; k++) begin
			dcfg(1'b0, k == 0, 3'h5);
			sel(1'b0, 1'b1);
			xfer({(k == 0) ? 3'h2 : 3'h5, 1'b0, 4'h0}, rx);
			check("refused_status", rx, 32'h0000_00FF);
			xfer(8'hA5, rx);
			check("refused_data", rx, 32'h0000_00FF);
			sel(1'b0, 1'b0);
			rd_chk(1, 8'h04, (k == 0) ? 32'h0000_0001 : 32'h0000_0011, "dev_status_refused");
		end
		finish_test();
	end
endmodule : tb

// ---- hw/sfd_link_if.sv ----
// Serial link carrier joining the host end and the device end.
interface sfd_link_if;
	import sfd_pkg::*;

	logic sclk;
	logic ss_n;
	logic mosi;
	logic miso_out;
	logic miso_oe;
	logic miso;

	// A released line floats to the pulled-up level.
	assign miso = miso_oe ? miso_out : MISO_IDLE;

	modport device (input sclk, input ss_n, input mosi, output miso_out, output miso_oe);
	modport host (output sclk, output ss_n, output mosi, input miso);
endinterface : sfd_link_if

// ---- hw/sfd_master_end.sv ----
// Host end: APB-controlled serial master that frames transactions and shifts bytes.
module sfd_master_end (
	input  wire logic                        ref_clk,
	input  wire logic                        rst,
	sfd_link_if.host                         link,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [sfd_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [sfd_pkg::DATA_W-1:0]  pwdata,
	output logic      [sfd_pkg::DATA_W-1:0]  prdata,
	output logic                             pready,
	output logic                             pslverr
);
	import sfd_pkg::*;

	typedef enum logic [1:0] {H_IDLE, H_RUN, H_TAIL} sfd_host_phase_type;

	typedef struct packed {
		logic                  miso_s1;
		logic                  miso_s2;
		sfd_host_phase_type    phase;
		logic [HALF_W-1:0]     half_cnt;
		logic [EDGE_CNT_W-1:0] edge_cnt;
		logic                  sel;
		logic                  cpol;
		logic                  cpha;
		logic [BYTE_W-1:0]     tx_sh;
		logic [BYTE_W-1:0]     rx_sh;
		logic [BYTE_W-1:0]     rx_byte;
		logic                  sclk;
		logic                  ss_n;
		logic                  mosi;
		logic                  pready;
		logic                  pslverr;
		logic [DATA_W-1:0]     prdata;
	} sfd_host_state_type;

	sfd_host_state_type st;
	sfd_host_state_type next_st;

	// ----------------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------------
	always_comb begin
		logic acc;
		logic tick;
		logic launch;
		acc    = psel & penable & st.pready & reg_mapped(paddr);
		tick   = (st.half_cnt == HALF_LAST);
		launch = (~st.edge_cnt[0]) == st.cpha;
		next_st = st;
		next_st.miso_s1 = link.miso;
		next_st.miso_s2 = st.miso_s1;

		unique case (st.phase)
			H_IDLE: begin
				next_st.half_cnt = '0;
				next_st.sclk     = st.cpol;
				// Select falls only once the clock rests at its idle level, so a polarity change is never an edge.
				next_st.ss_n     = ~(st.sel & (st.sclk == st.cpol));
				if (acc & pwrite & (reg_index(paddr) == REG_TX) & st.sel & ~st.ss_n) begin
					next_st.phase    = H_RUN;
					next_st.edge_cnt = '0;
					if (st.cpha) begin
						next_st.tx_sh = pwdata[BYTE_W-1:0];
					end else begin
						next_st.mosi  = pwdata[BYTE_W-1];
						next_st.tx_sh = {pwdata[BYTE_W-2:0], 1'b0};
					end
				end
			end
			H_RUN: begin
				next_st.half_cnt = st.half_cnt + 1'b1;
				if (tick) begin
					next_st.half_cnt = '0;
					next_st.sclk     = ~st.sclk;
					next_st.edge_cnt = st.edge_cnt + 1'b1;
					if (launch) begin
						next_st.mosi  = st.tx_sh[BYTE_W-1];
						next_st.tx_sh = {st.tx_sh[BYTE_W-2:0], 1'b0};
					end else begin
						next_st.rx_sh = {st.rx_sh[BYTE_W-2:0], st.miso_s2};
					end
					if (st.edge_cnt == EDGE_LAST) begin
						next_st.phase = H_TAIL;
					end
				end
			end
			H_TAIL: begin
				// Half a period of hold lets the device see the last edge before select may rise.
				next_st.half_cnt = st.half_cnt + 1'b1;
				if (tick) begin
					next_st.half_cnt = '0;
					next_st.rx_byte  = st.rx_sh;
					next_st.phase    = H_IDLE;
				end
			end
			default: next_st.phase = H_IDLE;
		endcase

		// Configuration is frozen while a byte is in flight.
		if (acc & pwrite & (reg_index(paddr) == REG_CTRL) & (st.phase == H_IDLE)) begin
			next_st.sel  = pwdata[HC_SEL];
			next_st.cpol = pwdata[HC_CPOL];
			next_st.cpha = pwdata[HC_CPHA];
		end

		next_st.pready = psel & penable & ~st.pready;
		if (psel & penable & ~st.pready) begin
			next_st.pslverr = ~reg_mapped(paddr);
			next_st.prdata  = '0;
			if (reg_mapped(paddr) & ~pwrite) begin
				unique case (reg_index(paddr))
					REG_CTRL:   next_st.prdata[HC_CPHA:0] = {st.cpha, st.cpol, st.sel};
					REG_STATUS: next_st.prdata[0] = (st.phase != H_IDLE);
					REG_TX:     next_st.prdata = '0;
					REG_RX:     next_st.prdata[BYTE_W-1:0] = st.rx_byte;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st      <= '0;
			st.cpol <= CPOL_RESET;
			st.cpha <= CPHA_RESET;
			st.sclk <= CPOL_RESET;
			st.ss_n <= SS_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign link.sclk = st.sclk;
	assign link.ss_n = st.ss_n;
	assign link.mosi = st.mosi;
	assign prdata    = st.prdata;
	assign pready    = st.pready;
	assign pslverr   = st.pslverr;
endmodule : sfd_master_end

// ---- hw/sfd_pkg.sv ----
// Shared constants, register map and decode helpers for both ends of the full-duplex serial link.
package sfd_pkg;

	// ----------------------------------------------------------------------
	// Clocking
	// ----------------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 40;
	localparam int SCLK_PERIOD_NS = 640;
	localparam int HALF_CYCLES    = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int HALF_W         = 4;
	localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(HALF_CYCLES - 1);

	// ----------------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------------
	localparam int ADDR_W        = 8;
	localparam int DATA_W        = 32;
	localparam int BYTE_W        = 8;
	localparam int BIT_CNT_W     = 3;
	localparam int ADDR_FIELD_W  = 3;
	localparam int EDGE_CNT_W    = 4;
	localparam int WORD_LSB      = 2;
	localparam int REG_SPAN_BITS = 4;

	// ----------------------------------------------------------------------
	// Register map, one aligned word each
	// ----------------------------------------------------------------------
	localparam logic [1:0] REG_CTRL   = 2'h0;
	localparam logic [1:0] REG_STATUS = 2'h1;
	localparam logic [1:0] REG_TX     = 2'h2;
	localparam logic [1:0] REG_RX     = 2'h3;

	// Device end fields.
	localparam int DC_ADDR_LSB = 0;
	localparam int DC_CPOL     = 3;
	localparam int DC_CPHA     = 4;
	localparam int DC_EN       = 5;
	localparam int DS_TXE      = 0;
	localparam int DS_OVR      = 2;
	localparam int DS_MODE_ERR = 4;

	// Host end fields.
	localparam int HC_SEL  = 0;
	localparam int HC_CPOL = 1;
	localparam int HC_CPHA = 2;

	// ----------------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------------
	localparam logic [ADDR_FIELD_W-1:0] ADDR_RESET = 3'h0;
	localparam logic CPOL_RESET   = 1'b0;
	localparam logic CPHA_RESET   = 1'b1;
	localparam logic ENABLE_RESET = 1'b0;
	localparam logic TXE_RESET    = 1'b1;
	localparam logic SS_IDLE      = 1'b1;
	localparam logic MISO_IDLE    = 1'b1;

	// ----------------------------------------------------------------------
	// Command and status byte layout, as bit-time index from zero
	// ----------------------------------------------------------------------
	localparam logic [BIT_CNT_W-1:0] ST_TXE_IDX    = 3'h4;
	localparam logic [BIT_CNT_W-1:0] ST_RXF_IDX    = 3'h5;
	localparam logic [BIT_CNT_W-1:0] ST_ACK_IDX    = 3'h6;
	localparam logic [BIT_CNT_W-1:0] CMD_ADDR_LAST = 3'h2;
	localparam logic [BIT_CNT_W-1:0] BYTE_LAST     = 3'h7;
	localparam int CMD_RW_BIT = 4;
	localparam logic [EDGE_CNT_W-1:0] EDGE_LAST = 4'hF;

	function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
		return (a[ADDR_W-1:REG_SPAN_BITS] == '0) && (a[WORD_LSB-1:0] == '0);
	endfunction : reg_mapped

	function automatic logic [1:0] reg_index(input logic [ADDR_W-1:0] a);
		return a[REG_SPAN_BITS-1:WORD_LSB];
	endfunction : reg_index

endpackage : sfd_pkg

// ---- hw/sfd_slave_end.sv ----
// Device end: full-duplex managed serial slave with command, status and data bytes behind APB.

// Function
// - Only the master starts, by lowering select
// - Master sends a command byte first
// - Master ends transaction by raising select
// - Select high aborts and returns to idle
// - System clock logic, serial edges synchronised in
// - CPU moves data through mapped registers
// - Polarity 0 edge roles per phase
// - Polarity 1 edge roles per phase
// - Only phase 1 modes are served
// - Status byte shifts out during command
// - Write streams while status shows room
// - Read alternates data and status bytes
// - Command address compared with own address
// - Fourth command bit gives direction
// - Status flags only in bit times 5-7
// - Transmit-empty high when nothing new waits
// - Receive-full high until CPU takes byte
// - Address-match flag only on own address
module sfd_slave_end (
	input  wire logic                        ref_clk,
	input  wire logic                        rst,
	sfd_link_if.device                       link,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [sfd_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [sfd_pkg::DATA_W-1:0]  pwdata,
	output logic      [sfd_pkg::DATA_W-1:0]  prdata,
	output logic                             pready,
	output logic                             pslverr
);
	import sfd_pkg::*;

	typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_WDATA, PH_RSTAT, PH_RDATA, PH_SKIP} sfd_phase_type;

	typedef struct packed {
		logic                    sclk_s1;
		logic                    sclk_s2;
		logic                    sclk_s3;
		logic                    ss_s1;
		logic                    ss_s2;
		logic                    mosi_s1;
		logic                    mosi_s2;
		sfd_phase_type           phase;
		logic [BIT_CNT_W-1:0]    bit_cnt;
		logic [BYTE_W-1:0]       in_sh;
		logic [BYTE_W-1:0]       tx_sh;
		logic [BYTE_W-1:0]       tx_buf;
		logic [BYTE_W-1:0]       rx_buf;
		logic [ADDR_FIELD_W-1:0] own_addr;
		logic                    cpol;
		logic                    cpha;
		logic                    enable;
		logic                    match;
		logic                    transmit_empty_flag;
		logic                    receive_full_flag;
		logic                    overrun;
		logic                    rd_full;
		logic                    miso;
		logic                    miso_oe;
		logic                    pready;
		logic                    pslverr;
		logic [DATA_W-1:0]       prdata;
	} sfd_slave_state_type;

	sfd_slave_state_type st;
	sfd_slave_state_type next_st;

	// ----------------------------------------------------------------------
	// Status byte bit for a bit time: {drive, value}
	// ----------------------------------------------------------------------
	// Every status bit stays released unless the address matched, so an unaddressed
	// device never fights the addressed one on a shared line.
	function automatic logic [1:0] status_bit(input logic [BIT_CNT_W-1:0] idx,
	                                          input logic transmit_empty_flag, input logic receive_full_flag, input logic match);
		logic [1:0] res;
		res = 2'h0;
		if (idx == ST_TXE_IDX) begin
			res = {match, transmit_empty_flag};
		end else if (idx == ST_RXF_IDX) begin
			res = {match, receive_full_flag};
		end else if (idx == ST_ACK_IDX) begin
			res = {match, match};
		end
		return res;
	endfunction : status_bit

	// ----------------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------------
	always_comb begin
		logic              rise;
		logic              fall;
		logic              cap;
		logic              lnch;
		logic              acc;
		logic              ovr_set;
		logic [BYTE_W-1:0] shifted;
		next_st = st;
		ovr_set = 1'b0;

		// Serial pins are asynchronous to ref_clk; edges are found on the second stage.
		next_st.sclk_s1 = link.sclk;
		next_st.sclk_s2 = st.sclk_s1;
		next_st.sclk_s3 = st.sclk_s2;
		next_st.ss_s1   = link.ss_n;
		next_st.ss_s2   = st.ss_s1;
		next_st.mosi_s1 = link.mosi;
		next_st.mosi_s2 = st.mosi_s1;
		rise    = st.sclk_s2 & ~st.sclk_s3;
		fall    = ~st.sclk_s2 & st.sclk_s3;
		cap     = (st.cpol ~^ st.cpha) ? rise : fall;
		lnch    = (st.cpol ~^ st.cpha) ? fall : rise;
		shifted = {st.in_sh[BYTE_W-2:0], st.mosi_s2};
		acc     = psel & penable & st.pready & reg_mapped(paddr);

		// ------------------------------------------------------------------
		// Serial engine
		// ------------------------------------------------------------------
		if (st.ss_s2) begin
			next_st.phase   = PH_IDLE;
			next_st.bit_cnt = '0;
			next_st.match   = 1'b0;
			next_st.miso_oe = 1'b0;
		end else begin
			if (st.phase == PH_IDLE) begin
				next_st.phase = (st.enable & st.cpha) ? PH_CMD : PH_SKIP;
			end
			if (lnch) begin
				unique case (st.phase)
					PH_CMD, PH_WDATA, PH_RSTAT: begin
						{next_st.miso_oe, next_st.miso} = status_bit(st.bit_cnt, st.transmit_empty_flag, st.receive_full_flag, st.match);
					end
					PH_RDATA: begin
						next_st.miso_oe = 1'b1;
						if (st.bit_cnt == '0) begin
							next_st.miso  = st.tx_buf[BYTE_W-1];
							next_st.tx_sh = st.tx_buf;
							next_st.transmit_empty_flag   = 1'b1;
						end else begin
							next_st.miso = st.tx_sh[~st.bit_cnt];
						end
					end
					PH_IDLE, PH_SKIP: next_st.miso_oe = 1'b0;
					default: next_st.miso_oe = 1'b0;
				endcase
			end
			if (cap) begin
				next_st.in_sh   = shifted;
				next_st.bit_cnt = st.bit_cnt + 1'b1;
				if ((st.phase == PH_CMD) && (st.bit_cnt == CMD_ADDR_LAST)) begin
					next_st.match = (shifted[ADDR_FIELD_W-1:0] == st.own_addr);
				end
				if (st.bit_cnt == BYTE_LAST) begin
					unique case (st.phase)
						PH_CMD: begin
							if (~st.match) begin
								next_st.phase = PH_SKIP;
							end else begin
								next_st.phase = shifted[CMD_RW_BIT] ? PH_RDATA : PH_WDATA;
							end
						end
						PH_WDATA: begin
							// A byte sent while the buffer is still full is dropped and flagged.
							if (~st.receive_full_flag) begin
								next_st.rx_buf = shifted;
								next_st.receive_full_flag    = 1'b1;
							end else begin
								next_st.overrun = 1'b1;
								ovr_set         = 1'b1;
							end
						end
						PH_RDATA: next_st.phase = PH_RSTAT;
						PH_RSTAT: next_st.phase = PH_RDATA;
						PH_IDLE, PH_SKIP: next_st.phase = st.phase;
						default: next_st.phase = PH_SKIP;
					endcase
				end
			end
		end

		// ------------------------------------------------------------------
		// APB slave, answer one cycle into the access phase
		// ------------------------------------------------------------------
		next_st.pready = psel & penable & ~st.pready;
		if (psel & penable & ~st.pready) begin
			next_st.pslverr = ~reg_mapped(paddr);
			next_st.prdata  = '0;
			next_st.rd_full = 1'b0;
			if (reg_mapped(paddr) & ~pwrite) begin
				unique case (reg_index(paddr))
					REG_CTRL:   next_st.prdata[DC_EN:0] = {st.enable, st.cpha, st.cpol, st.own_addr};
					REG_STATUS: next_st.prdata[DS_MODE_ERR:0] = {~st.cpha, st.phase != PH_IDLE,
					                                            st.overrun, st.receive_full_flag, st.transmit_empty_flag};
					REG_TX:     next_st.prdata[BYTE_W-1:0] = st.tx_buf;
					REG_RX: begin
						next_st.prdata[BYTE_W-1:0] = st.rx_buf;
						next_st.rd_full = st.receive_full_flag;
					end
				endcase
			end
		end
		if (acc & pwrite) begin
			unique case (reg_index(paddr))
				// A change of mode or address in mid-frame corrupts that frame.
				REG_CTRL: begin
					next_st.own_addr = pwdata[DC_ADDR_LSB +: ADDR_FIELD_W];
					next_st.cpol     = pwdata[DC_CPOL];
					next_st.cpha     = pwdata[DC_CPHA];
					next_st.enable   = pwdata[DC_EN];
				end
				REG_STATUS: begin
					if (pwdata[DS_OVR] & ~ovr_set) begin
						next_st.overrun = 1'b0;
					end
				end
				REG_TX: begin
					// New data written in the cycle a byte is picked up stays pending.
					next_st.tx_buf = pwdata[BYTE_W-1:0];
					next_st.transmit_empty_flag    = 1'b0;
				end
				REG_RX: next_st.rx_buf = st.rx_buf;
			endcase
		end
		// Only a read that saw a full buffer frees it; a byte landing meanwhile is kept.
		if (acc & ~pwrite & (reg_index(paddr) == REG_RX) & st.rd_full) begin
			next_st.receive_full_flag = 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st          <= '0;
			st.ss_s1    <= SS_IDLE;
			st.ss_s2    <= SS_IDLE;
			st.own_addr <= ADDR_RESET;
			st.cpol     <= CPOL_RESET;
			st.cpha     <= CPHA_RESET;
			st.sclk_s1  <= CPOL_RESET;
			st.sclk_s2  <= CPOL_RESET;
			st.sclk_s3  <= CPOL_RESET;
			st.enable   <= ENABLE_RESET;
			st.transmit_empty_flag      <= TXE_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign link.miso_out = st.miso;
	assign link.miso_oe  = st.miso_oe;
	assign prdata        = st.prdata;
	assign pready        = st.pready;
	assign pslverr       = st.pslverr;
endmodule : sfd_slave_end
